// ==== core/tsp_params.svh ====
// Operation
// - Power-up starts continuous conversion, registers default.
// - Before first conversion the word is invalid.
// - Output changes on falling, input sampled rising.
// - Frame is 16 transmit plus 16 receive clocks.
// - Data line released while select is high.
// - Host lowers select only while clock low.
// - First bit driven as soon as select falls.
// - Select may rise anytime in transmit phase.
// - Result lands only after select returns high.
// - Receive phase follows sixteenth clock, up to 16.
// - Last eight received bits are decoded.
// - Zeros select conversion, ones select shutdown.
// - Host sends only all-zeros or all-ones codes; this host sends whatever command byte is written to it.
// - Upper byte of mode word is ignored.
// - Serial port keeps working in shutdown.
// - Shutdown transmits the identification word.
// - Top five identification bits hold maker code.
// - Temperature is 14-bit two's complement, bits 15:2.
// - Two lowest transmitted bits are always one.
// - Most significant bit is sent first.
// - Read, shutdown, read identity, resume in one select.
// - Wait 300 ms after resuming before trusting data.
// - Reads never interrupt a conversion; restart after read.
`ifndef TSP_PARAMS_SVH
`define TSP_PARAMS_SVH
`define TSP_CTRL_OFS 8'h00
`define TSP_STATUS_OFS 8'h04
`define TSP_RXDATA_OFS 8'h08
`define TSP_CTRL_CMD_LSB 0
`define TSP_CTRL_LEN_LSB 8
`define TSP_CTRL_KEEP_BIT 16
`define TSP_STAT_BUSY_BIT 0
`define TSP_STAT_READY_BIT 1
`define TSP_STAT_SEL_BIT 2
`define TSP_CMD_CONT 8'h00
`define TSP_CMD_SHDN 8'hFF
`define TSP_TX_CLKS 6'h10
`define TSP_FRAME_CLKS 6'h20
`define TSP_CMD_DONE_CLKS 6'h18
`define TSP_LOW_ONES 2'h3
// The maker and part codes are arbitrary values.
`define TSP_MFR_ID 5'h0A
`define TSP_DEV_ID 9'h0C5
`define TSP_CLK_NS 10
`define TSP_SCLK_PERIOD_NS 160
`define TSP_SETUP_NS 100
`define TSP_GAP_NS 200
`define TSP_CONV_TIME_MS 200
`define TSP_WAKE_TIME_MS 300
`define TSP_HALF_CYC ((`TSP_SCLK_PERIOD_NS / 2) / `TSP_CLK_NS)
`define TSP_SETUP_CYC ((`TSP_SETUP_NS + `TSP_CLK_NS - 1) / `TSP_CLK_NS)
`define TSP_GAP_CYC ((`TSP_GAP_NS + `TSP_CLK_NS - 1) / `TSP_CLK_NS)
`define TSP_CONV_CYC (`TSP_CONV_TIME_MS * 1000000 / `TSP_CLK_NS)
`define TSP_WAKE_CYC (`TSP_WAKE_TIME_MS * 1000000 / `TSP_CLK_NS)
`endif

// ==== core/tsp_pkg.sv ====
package tsp_pkg;
	typedef enum logic [2:0] {
		TSP_C_IDLE = 3'h1,
		TSP_C_RUN = 3'h2,
		TSP_C_WAIT = 3'h4
	} tsp_conv_e;
	typedef enum logic [5:0] {
		TSP_H_IDLE = 6'h01,
		TSP_H_SETUP = 6'h02,
		TSP_H_HIGH = 6'h04,
		TSP_H_LOW = 6'h08,
		TSP_H_HOLD = 6'h10,
		TSP_H_PAUSE = 6'h20
	} tsp_host_e;
	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_d;
		logic sc_s1;
		logic sc_s2;
		logic sc_d;
		logic di_s1;
		logic di_s2;
		logic active;
		logic oe;
		logic [15:0] tx;
		logic [7:0] rx;
		logic [5:0] cnt;
		logic shdn;
		logic valid;
		logic [13:0] result;
		logic [13:0] pend;
		tsp_conv_e cstate;
		logic [31:0] ccnt;
	} tsp_dev_s;
	typedef struct packed {
		tsp_host_e state;
		logic [7:0] hcnt;
		logic [4:0] bitpos;
		logic [5:0] remain;
		logic keep;
		logic [15:0] tx;
		logic [15:0] rx;
		logic sclk;
		logic cs_n;
		logic oe;
		logic di_s1;
		logic di_s2;
		logic [31:0] wake;
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
	} tsp_host_s;
endpackage : tsp_pkg

// ==== core/tsp_link_if.sv ====
`timescale 1ns/1ps
interface tsp_link_if;
	logic sclk;
	logic cs_n;
	logic host_sio_out;
	logic host_sio_oe;
	logic dev_sio_out;
	logic dev_sio_oe;
	logic sio;
	// The host wins a brief overlap at the turn-around; an idle line floats high.
	assign sio = host_sio_oe ? host_sio_out : (dev_sio_oe ? dev_sio_out : 1'b1);
	modport host (
		output sclk,
		output cs_n,
		output host_sio_out,
		output host_sio_oe,
		input sio
	);
	modport dev (
		input sclk,
		input cs_n,
		input sio,
		output dev_sio_out,
		output dev_sio_oe
	);
endinterface : tsp_link_if

// ==== core/tsp_device.sv ====
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "tsp_params.svh"
module tsp_device #(
	parameter logic [31:0] CONV_CYCLES = `TSP_CONV_CYC,
	parameter logic [4:0] MFR_ID = `TSP_MFR_ID,
	parameter logic [8:0] DEV_ID = `TSP_DEV_ID
) (
	input wire logic hclk,
	input wire logic hresetn,
	tsp_link_if.dev link,
	input wire logic [13:0] temp_code,
	output logic temp_valid,
	output logic shutdown,
	output logic conv_busy
);
	import tsp_pkg::*;

	// MFR_ID and DEV_ID defaults are arbitrary values.
	localparam tsp_dev_s RST = '{
		cs_s1: 1'b1,
		cs_s2: 1'b1,
		cs_d: 1'b1,
		sc_s1: 1'b0,
		sc_s2: 1'b0,
		sc_d: 1'b0,
		di_s1: 1'b0,
		di_s2: 1'b0,
		active: 1'b0,
		oe: 1'b0,
		tx: 16'h0000,
		rx: 8'h00,
		cnt: 6'h00,
		shdn: 1'b0,
		valid: 1'b0,
		result: 14'h0000,
		pend: 14'h0000,
		cstate: TSP_C_RUN,
		ccnt: CONV_CYCLES - 32'h1
	};

	tsp_dev_s s;
	tsp_dev_s next_s;
	logic cs_fall;
	logic cs_rise;
	logic sc_rise;
	logic sc_fall;
	logic [7:0] rx_last;

	// Maps a received command byte onto the shutdown state; other codes keep it.
	function automatic logic decode_cmd(input logic [7:0] cmd, input logic cur);
		logic res;
		res = cur;
		if (cmd == `TSP_CMD_CONT) begin
			res = 1'b0;
		end else if (cmd == `TSP_CMD_SHDN) begin
			res = 1'b1;
		end
		return res;
	endfunction : decode_cmd

	// Builds the word that the next transmit phase shifts out.
	function automatic logic [15:0] out_word(input logic sd, input logic [13:0] res);
		logic [15:0] w;
		w = {res, `TSP_LOW_ONES};
		if (sd) begin
			w = {MFR_ID, DEV_ID, `TSP_LOW_ONES};
		end
		return w;
	endfunction : out_word

	assign cs_fall = s.cs_d & ~s.cs_s2;
	assign cs_rise = ~s.cs_d & s.cs_s2;
	assign sc_rise = ~s.sc_d & s.sc_s2;
	assign sc_fall = s.sc_d & ~s.sc_s2;
	assign rx_last = {s.rx[6:0], s.di_s2};

	always_comb begin
		next_s = s;
		next_s.cs_s1 = link.cs_n;
		next_s.cs_s2 = s.cs_s1;
		next_s.cs_d = s.cs_s2;
		next_s.sc_s1 = link.sclk;
		next_s.sc_s2 = s.sc_s1;
		next_s.sc_d = s.sc_s2;
		next_s.di_s1 = link.sio;
		next_s.di_s2 = s.di_s1;

		if (cs_fall) begin
			// The leading bit is on the line before the first rising edge.
			next_s.active = 1'b1;
			next_s.oe = 1'b1;
			next_s.tx = out_word(s.shdn, s.result);
			next_s.cnt = 6'h00;
		end else if (cs_rise) begin
			// Select may end the frame at any bit count without harm.
			next_s.active = 1'b0;
			next_s.oe = 1'b0;
			if (s.cnt >= `TSP_CMD_DONE_CLKS && s.cnt < `TSP_FRAME_CLKS) begin
				next_s.shdn = decode_cmd(s.rx, s.shdn);
			end
		end else if (s.active) begin
			if (sc_rise && s.cnt < `TSP_FRAME_CLKS) begin
				next_s.cnt = s.cnt + 6'h01;
				if (s.cnt >= `TSP_TX_CLKS) begin
					next_s.rx = rx_last;
				end
				if (s.cnt == `TSP_FRAME_CLKS - 6'h01) begin
					next_s.shdn = decode_cmd(rx_last, s.shdn);
				end
			end
			if (sc_fall) begin
				if (s.cnt > 6'h00 && s.cnt < `TSP_TX_CLKS) begin
					next_s.tx = {s.tx[14:0], 1'b1};
				end
				if (s.cnt == `TSP_TX_CLKS) begin
					next_s.oe = 1'b0;
				end
				if (s.cnt == `TSP_FRAME_CLKS) begin
					// A select held low starts the next frame here.
					next_s.tx = out_word(s.shdn, s.result);
					next_s.oe = 1'b1;
					next_s.cnt = 6'h00;
				end
			end
		end

		case (s.cstate)
			TSP_C_RUN: begin
				if (s.ccnt != 32'h0) begin
					next_s.ccnt = s.ccnt - 32'h1;
				end else if (s.active) begin
					// A frame in progress holds the new result back.
					next_s.pend = temp_code;
					next_s.cstate = TSP_C_WAIT;
				end else begin
					next_s.result = temp_code;
					next_s.valid = 1'b1;
					next_s.ccnt = CONV_CYCLES - 32'h1;
					if (s.shdn) begin
						next_s.cstate = TSP_C_IDLE;
					end
				end
			end
			TSP_C_WAIT: begin
				if (!s.active) begin
					next_s.result = s.pend;
					next_s.valid = 1'b1;
					next_s.ccnt = CONV_CYCLES - 32'h1;
					next_s.cstate = s.shdn ? TSP_C_IDLE : TSP_C_RUN;
				end
			end
			TSP_C_IDLE: begin
				next_s.valid = 1'b0;
				if (!s.shdn) begin
					next_s.ccnt = CONV_CYCLES - 32'h1;
					next_s.cstate = TSP_C_RUN;
				end
			end
			default: begin
				next_s.cstate = TSP_C_RUN;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	// The port logic stays alive in shutdown; only conversions stop.
	assign link.dev_sio_out = s.tx[15];
	assign link.dev_sio_oe = s.oe;
	assign temp_valid = s.valid;
	assign shutdown = s.shdn;
	assign conv_busy = (s.cstate == TSP_C_RUN);
endmodule : tsp_device

// ==== core/tsp_host.sv ====
`timescale 1ns/1ps
`include "tsp_params.svh"
module tsp_host #(
	parameter logic [31:0] WAKE_CYCLES = `TSP_WAKE_CYC,
	parameter logic [7:0] HALF_CYCLES = 8'(`TSP_HALF_CYC)
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	tsp_link_if.host link
);
	import tsp_pkg::*;

	localparam logic [7:0] SETUP_CYC = 8'(`TSP_SETUP_CYC);
	localparam logic [7:0] GAP_CYC = 8'(`TSP_GAP_CYC);

	tsp_host_s s;
	tsp_host_s next_s;
	logic busy;
	logic start;
	logic [7:0] cmd;
	logic [4:0] bit_nx;

	assign busy = (s.state != TSP_H_IDLE) && (s.state != TSP_H_PAUSE);
	assign start = s.a_wr && (s.a_addr == `TSP_CTRL_OFS) && !busy;
	assign cmd = hwdata[`TSP_CTRL_CMD_LSB +: 8];
	assign bit_nx = s.bitpos + 5'h01;

	always_comb begin
		next_s = s;
		next_s.di_s1 = link.sio;
		next_s.di_s2 = s.di_s1;
		next_s.a_wr = hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
		next_s.a_addr = haddr[7:0];
		if (hsel && hready && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				`TSP_STATUS_OFS: next_s.hrdata = {29'h0, !s.cs_n, s.wake == 32'h0, busy};
				`TSP_RXDATA_OFS: next_s.hrdata = {16'h0000, s.rx};
				default: next_s.hrdata = 32'h0;
			endcase
		end
		if (s.wake != 32'h0) begin
			next_s.wake = s.wake - 32'h1;
		end
		if (s.hcnt != 8'h00) begin
			next_s.hcnt = s.hcnt - 8'h01;
		end
		if (start) begin
			// Both bytes carry the command, so the ignored upper byte is harmless.
			next_s.tx = {cmd, cmd};
			next_s.remain = hwdata[`TSP_CTRL_LEN_LSB +: 6];
			next_s.keep = hwdata[`TSP_CTRL_KEEP_BIT];
			next_s.wake = WAKE_CYCLES;
			if (s.state == TSP_H_PAUSE) begin
				next_s.state = TSP_H_LOW;
				next_s.hcnt = HALF_CYCLES - 8'h01;
			end else begin
				next_s.state = TSP_H_SETUP;
				next_s.cs_n = 1'b0;
				next_s.bitpos = 5'h00;
				next_s.hcnt = SETUP_CYC - 8'h01;
			end
		end
		case (s.state)
			TSP_H_SETUP, TSP_H_LOW: begin
				if (s.hcnt == 8'h00) begin
					next_s.state = TSP_H_HIGH;
					next_s.sclk = 1'b1;
					next_s.hcnt = HALF_CYCLES - 8'h01;
					if (!s.bitpos[4]) begin
						next_s.rx = {s.rx[14:0], s.di_s2};
					end
				end
			end
			TSP_H_HIGH: begin
				if (s.hcnt == 8'h00) begin
					next_s.sclk = 1'b0;
					next_s.bitpos = bit_nx;
					next_s.oe = bit_nx[4];
					if (s.bitpos[4]) begin
						next_s.tx = {s.tx[14:0], 1'b0};
					end
					next_s.remain = s.remain - 6'h01;
					next_s.hcnt = HALF_CYCLES - 8'h01;
					next_s.state = TSP_H_LOW;
					if (s.remain <= 6'h01) begin
						if (s.keep) begin
							next_s.state = TSP_H_PAUSE;
						end else begin
							next_s.state = TSP_H_HOLD;
							next_s.cs_n = 1'b1;
							next_s.oe = 1'b0;
							next_s.hcnt = GAP_CYC - 8'h01;
						end
					end
				end
			end
			TSP_H_HOLD: begin
				if (s.hcnt == 8'h00) begin
					next_s.state = TSP_H_IDLE;
				end
			end
			TSP_H_IDLE, TSP_H_PAUSE: begin
			end
			default: begin
				next_s.state = TSP_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '{state: TSP_H_IDLE, cs_n: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign link.sclk = s.sclk;
	assign link.cs_n = s.cs_n;
	assign link.host_sio_out = s.tx[15];
	assign link.host_sio_oe = s.oe;
endmodule : tsp_host

// ==== test/tsp_link_chk.sv ====
`timescale 1ns/1ps
module tsp_link_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic host_sio_out,
	input wire logic host_sio_oe,
	input wire logic dev_sio_out,
	input wire logic dev_sio_oe
);
	// Counts serial clock rises within one selection, modulo one frame.
	logic [4:0] cnt;
	logic sclk_d;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 5'h00;
			sclk_d <= 1'b0;
		end else begin
			sclk_d <= sclk;
			if (cs_n) begin
				cnt <= 5'h00;
			end else if (sclk && !sclk_d) begin
				cnt <= cnt + 5'h01;
			end
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_open;
		$fell(cs_n);
	endsequence
	sequence s_high;
		sclk && sclk_d && !cs_n;
	endsequence
	property p_setup;
		s_open |-> (!sclk) [*8];
	endproperty
	a_setup: assert property (p_setup) else $error("Clock rose too soon.");
	property p_first;
		s_open |-> ##[1:6] dev_sio_oe;
	endproperty
	a_first: assert property (p_first) else $error("First bit late.");
	property p_release;
		cs_n [*6] |-> !dev_sio_oe;
	endproperty
	a_release: assert property (p_release) else $error("Line not released.");
	property p_idle_clk;
		cs_n |-> !sclk;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("Clock outside frame.");
	property p_dev_edge;
		(dev_sio_oe && $past(dev_sio_oe) && $changed(dev_sio_out)) |-> !sclk;
	endproperty
	a_dev_edge: assert property (p_dev_edge) else $error("Device bit moved high.");
	property p_host_edge;
		(host_sio_oe && $past(host_sio_oe) && $changed(host_sio_out)) |-> !sclk;
	endproperty
	a_host_edge: assert property (p_host_edge) else $error("Host bit moved high.");
	property p_dev_phase;
		(s_high and dev_sio_oe) |-> (cnt >= 5'h01 && cnt <= 5'h10);
	endproperty
	a_dev_phase: assert property (p_dev_phase) else $error("Device drove late.");
	property p_host_phase;
		(s_high and host_sio_oe) |-> (cnt > 5'h10 || cnt == 5'h00);
	endproperty
	a_host_phase: assert property (p_host_phase) else $error("Host drove early.");
	property p_low_ones;
		(s_high and dev_sio_oe && cnt >= 5'h0F) |-> dev_sio_out;
	endproperty
	a_low_ones: assert property (p_low_ones) else $error("Low bits not one.");
endmodule : tsp_link_chk

// ==== test/test_serial_temp_sensor_port.sv ====
`timescale 1ns/1ps
`include "tsp_params.svh"
module test_serial_temp_sensor_port;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic [31:0] hrdata;
	logic [13:0] temp_code;
	logic temp_valid;
	logic shutdown;
	logic conv_busy;
	logic hresp;
	logic [31:0] d;
	logic [15:0] id_w;
	int fail_count;
	int cmp_count;
	int cycles;
	tsp_link_if tsp_link_if_inst ();
	tsp_host #(.WAKE_CYCLES(32'h1F4)) tsp_host_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .link(tsp_link_if_inst));
	tsp_device #(.CONV_CYCLES(32'h7D0)) tsp_device_inst (.hclk(hclk), .hresetn(hresetn),
		.link(tsp_link_if_inst), .temp_code(temp_code), .temp_valid(temp_valid),
		.shutdown(shutdown), .conv_busy(conv_busy));
	tsp_link_chk tsp_link_chk_inst (.hclk(hclk), .hresetn(hresetn),
		.sclk(tsp_link_if_inst.sclk), .cs_n(tsp_link_if_inst.cs_n),
		.host_sio_out(tsp_link_if_inst.host_sio_out), .host_sio_oe(tsp_link_if_inst.host_sio_oe),
		.dev_sio_out(tsp_link_if_inst.dev_sio_out), .dev_sio_oe(tsp_link_if_inst.dev_sio_oe));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	task automatic final_report;
		$display("Compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : bus
	// Starts one transfer, waits until the host is idle or paused, then fetches the received word.
	task automatic frame(input logic [7:0] c, input logic [5:0] n, input logic k);
		bus(1'b1, 32'h0, {15'h0, k, 2'h0, n, c});
		do bus(1'b0, 32'h4, 32'h0); while (d[0] !== 1'b0);
		bus(1'b0, 32'h8, 32'h0);
	endtask : frame
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		temp_code = 14'h3CE0;
		id_w = {`TSP_MFR_ID, `TSP_DEV_ID, `TSP_LOW_ONES};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({15'h0, shutdown}, 16'h0000);
		frame(8'h00, 6'h20, 1'b0);
		chk(d[15:0], 16'h0003);
		wait (temp_valid === 1'b1);
		frame(8'hFF, 6'h20, 1'b0);
		chk(d[15:0], 16'hF383);
		chk({15'h0, shutdown}, 16'h0001);
		frame(8'h5A, 6'h20, 1'b0);
		chk(d[15:0], id_w);
		// Lets the conversion that was running at shutdown finish.
		repeat (2100) @(posedge hclk);
		chk({14'h0, shutdown, temp_valid}, 16'h0002);
		chk({15'h0, conv_busy}, 16'h0000);
		frame(8'h00, 6'h08, 1'b0);
		chk({15'h0, shutdown}, 16'h0001);
		frame(8'h00, 6'h18, 1'b0);
		chk({15'h0, shutdown}, 16'h0000);
		chk({15'h0, conv_busy}, 16'h0001);
		temp_code <= 14'h0320;
		@(posedge hclk);
		wait (temp_valid === 1'b1);
		frame(8'hFF, 6'h20, 1'b1);
		chk(d[15:0], 16'h0C83);
		bus(1'b0, 32'h4, 32'h0);
		chk({13'h0, d[2:0]}, 16'h0006);
		chk({15'h0, hresp}, 16'h0000);
		frame(8'h00, 6'h20, 1'b0);
		chk(d[15:0], id_w);
		chk({15'h0, shutdown}, 16'h0000);
		final_report();
	end
endmodule : test_serial_temp_sensor_port
